// >>> verilog/fag_pkg.sv
/*
  Shared constants and types for the fault aggregation and host wakeup block:
  register offsets, field positions, reset values, fault tree layout and timing.
  Assumes a 100 MHz device clock and an APB register port with byte addresses.
*/
`default_nettype none
package fag_pkg;
  // Fault tree shape: groups, level-2 bits per group, level-3 bits per group
  localparam int NG = 4;
  localparam int NS = 2;
  localparam int NB = 8;
  localparam int SUBW = NB / NS;
  localparam int NL2 = NG * NS;
  localparam int NL3 = NG * NB;
  localparam int NEXT = NL3 - NB;

  // Register byte offsets
  localparam logic [7:0] ADDR_SUMMARY = 8'h00;
  localparam logic [7:0] ADDR_LEVEL2 = 8'h04;
  localparam logic [7:0] ADDR_LEVEL3 = 8'h08;
  localparam logic [7:0] ADDR_MASK = 8'h0C;
  localparam logic [7:0] ADDR_CONF = 8'h10;
  localparam logic [7:0] ADDR_WAKE = 8'h14;
  localparam logic [7:0] ADDR_CLEAR = 8'h18;
  localparam logic [7:0] ADDR_STATUS = 8'h1C;

  // Configuration register fields
  localparam int CONF_W = 6;
  localparam int CONF_HB_TX = 0;
  localparam int CONF_FAULT_OUT = 1;
  localparam int CONF_TONE_RX = 2;
  localparam int CONF_SNIFF_DIS = 3;
  localparam int CONF_SNIFF_EN = 4;
  localparam int CONF_DIR_SEL = 5;
  localparam logic [CONF_W-1:0] CONF_RESET = 6'h02;
  localparam logic [NG-1:0] MASK_RESET = 4'h0;

  // Wake register fields
  localparam int WAKE_FORCE = 2;
  localparam int WAKE_PIN = 8;
  localparam int WAKE_LATCHED = 9;
  localparam logic [1:0] WAKE_DIS_RESET = 2'h0;
  localparam logic [1:0] WAKE_DIS_ALL = 2'h3;

  // System group (group 0) level-3 bit positions
  localparam int SYS_FTONE = 0;
  localparam int SYS_HEARTBEAT_MISSING_FLAG = 1;
  localparam int SYS_HEARTBEAT_TOO_FAST_FLAG = 2;
  localparam int SYS_AON = 3;
  localparam int SYS_FACT = 4;
  localparam int SYS_CONF = 5;
  localparam int SYS_WAKE = 6;
  localparam int SYS_SNIFF = 7;

  // Timing
  localparam int CLK_MHZ = 100;
  localparam int SNIFF_IDLE_NS = 2000;
  localparam int SNIFF_IDLE_CYC = (SNIFF_IDLE_NS * CLK_MHZ / 1000 < 1) ? 1 : SNIFF_IDLE_NS * CLK_MHZ / 1000;
  localparam int SNIFF_THRESHOLD = 32;
  localparam int HB_PERIOD_US = 1000;
  localparam int FT_GAP_US = 1500;
  localparam int VALIDATE_US = 5000;
  localparam int FT_BURSTS = 3;

  typedef enum logic [1:0] {MODE_ACTIVE, MODE_SLEEP, MODE_SHUTDOWN, MODE_VALIDATE} fag_mode_t;

  // Level faults from the rest of the device that may wake the host
  typedef struct packed {
    logic heartbeat_missing_flag;
    logic heartbeat_too_fast_flag;
    logic always_on_switch_fail;
    logic factory_check_error;
    logic config_monitor_error;
  } fag_sys_cond_t;

  // One received tone burst from the full tone receiver
  typedef struct packed {
    logic burst;
    logic is_fault;
  } fag_tone_t;
endpackage
`default_nettype wire

// >>> verilog/fag_top.sv
/*
  Fault aggregation, fault pin, tone detection, sniffer and host wakeup logic.
  Assumes one 100 MHz clock, synchronous inputs, an APB master on the register
  port and an analog front end that turns tones and couplets into pulses.
*/
`timescale 1ns/1ps
`default_nettype none
module fag_top #(
  parameter int HB_PERIOD_CYC = fag_pkg::HB_PERIOD_US * fag_pkg::CLK_MHZ,
  parameter int FT_GAP_CYC = fag_pkg::FT_GAP_US * fag_pkg::CLK_MHZ,
  parameter int VALIDATE_CYC = fag_pkg::VALIDATE_US * fag_pkg::CLK_MHZ,
  parameter int SNIFF_THR = fag_pkg::SNIFF_THRESHOLD
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic goto_active,
  input wire logic goto_sleep,
  input wire logic goto_shutdown,
  input wire logic frame_fault_embed,
  input wire fag_pkg::fag_tone_t tone_rx,
  input wire logic sniff_couplet_neg,
  input wire logic sniff_couplet_pos,
  input wire fag_pkg::fag_sys_cond_t sys_cond,
  input wire logic [fag_pkg::NEXT-1:0] fault_cond,
  input wire logic host_wake_pin_level,
  output logic fault_out_o,
  output logic fault_out_oe_n,
  output logic host_wake_o,
  output logic host_wake_oe_n,
  output logic hb_tx_pulse,
  output logic tone_tx_high_side,
  output logic tone_rx_active,
  output var fag_pkg::fag_mode_t mode
);
  localparam int HBW = $clog2(HB_PERIOD_CYC + 1);
  localparam int GPW = $clog2(FT_GAP_CYC + 1);
  localparam int VLW = $clog2(VALIDATE_CYC + 1);
  localparam int SCW = $clog2(SNIFF_THR + 1);
  localparam int SIW = $clog2(fag_pkg::SNIFF_IDLE_CYC + 1);

  logic [fag_pkg::NL3-1:0] l3_q, cond_vec, clr_vec;
  logic [fag_pkg::NL2-1:0] l2;
  logic [fag_pkg::NG-1:0] summary, mask_q, clr_grp;
  logic [fag_pkg::CONF_W-1:0] conf_q;
  logic [1:0] wake_dis_q;
  logic [31:0] rd_d;
  logic acc, wr_en, rd_take, hit, force_wr, wake_trig, wake_q, ftone_set, sniff_hit;
  logic tone_ok, tone_confirm, armed_q, dis_all;
  logic [HBW-1:0] hb_cnt_q;
  logic [GPW-1:0] gap_q;
  logic [1:0] burst_q;
  logic [VLW-1:0] val_q;
  logic [SCW-1:0] sniff_cnt_q;
  logic [SIW-1:0] idle_q;
  fag_pkg::fag_mode_t mode_q, mode_d;

  // APB decode; one wait state so read data and pready leave flops together
  assign acc = psel & penable;
  assign rd_take = acc & ~pready;
  assign wr_en = acc & pready & pwrite;
  assign force_wr = wr_en && paddr == fag_pkg::ADDR_WAKE && pwdata[fag_pkg::WAKE_FORCE];
  assign clr_grp = (wr_en && paddr == fag_pkg::ADDR_CLEAR) ? pwdata[fag_pkg::NG-1:0] : '0;
  assign dis_all = wake_dis_q == fag_pkg::WAKE_DIS_ALL;

  // Read mux; unmapped addresses read zero and raise pslverr
  always_comb
  begin
    rd_d = 32'h0;
    hit = 1'b1;
    if (paddr == fag_pkg::ADDR_SUMMARY)
      rd_d[fag_pkg::NG-1:0] = summary;
    else if (paddr == fag_pkg::ADDR_LEVEL2)
      rd_d[fag_pkg::NL2-1:0] = l2;
    else if (paddr == fag_pkg::ADDR_LEVEL3)
      rd_d[fag_pkg::NL3-1:0] = l3_q;
    else if (paddr == fag_pkg::ADDR_MASK)
      rd_d[fag_pkg::NG-1:0] = mask_q;
    else if (paddr == fag_pkg::ADDR_CONF)
      rd_d[fag_pkg::CONF_W-1:0] = conf_q;
    else if (paddr == fag_pkg::ADDR_WAKE)
    begin
      rd_d[1:0] = wake_dis_q;
      rd_d[fag_pkg::WAKE_PIN] = host_wake_pin_level;
      rd_d[fag_pkg::WAKE_LATCHED] = wake_q;
    end
    else if (paddr == fag_pkg::ADDR_STATUS)
    begin
      rd_d[1:0] = mode_q;
      rd_d[2] = armed_q;
    end
    else if (paddr != fag_pkg::ADDR_CLEAR)
      hit = 1'b0;
  end

  // Bus answer flops
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end
    else
    begin
      pready <= rd_take;
      pslverr <= rd_take & ~hit;
      if (rd_take && !pwrite)
        prdata <= rd_d;
    end
  end

  // Software registers; pslverr writes to unmapped offsets have no effect
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      mask_q <= fag_pkg::MASK_RESET;
      conf_q <= fag_pkg::CONF_RESET;
      wake_dis_q <= fag_pkg::WAKE_DIS_RESET;
    end
    else if (wr_en)
    begin
      if (paddr == fag_pkg::ADDR_MASK)
        mask_q <= pwdata[fag_pkg::NG-1:0];
      else if (paddr == fag_pkg::ADDR_CONF)
        conf_q <= pwdata[fag_pkg::CONF_W-1:0];
      else if (paddr == fag_pkg::ADDR_WAKE)
        wake_dis_q <= pwdata[1:0];
    end
  end

  // Fault causes: system group built here, other groups from the device
  always_comb
  begin
    cond_vec = {fault_cond, {fag_pkg::NB{1'b0}}};
    cond_vec[fag_pkg::SYS_FTONE] = ftone_set;
    cond_vec[fag_pkg::SYS_HEARTBEAT_MISSING_FLAG] = sys_cond.heartbeat_missing_flag;
    cond_vec[fag_pkg::SYS_HEARTBEAT_TOO_FAST_FLAG] = sys_cond.heartbeat_too_fast_flag;
    cond_vec[fag_pkg::SYS_AON] = sys_cond.always_on_switch_fail;
    cond_vec[fag_pkg::SYS_FACT] = sys_cond.factory_check_error;
    cond_vec[fag_pkg::SYS_CONF] = sys_cond.config_monitor_error;
    cond_vec[fag_pkg::SYS_WAKE] = wake_q & ~dis_all;
    cond_vec[fag_pkg::SYS_SNIFF] = sniff_hit;
  end

  // Tree: level-2 is a pure OR of the latched level-3 bits; summary ORs each group's level-2 bits and is gated off by its mask bit
  for (genvar g = 0; g < fag_pkg::NG; g++)
  begin : g_grp
    for (genvar s = 0; s < fag_pkg::NS; s++)
    begin : g_sub
      assign l2[g*fag_pkg::NS+s] = |l3_q[g*fag_pkg::NB+s*fag_pkg::SUBW +: fag_pkg::SUBW];
    end
    assign summary[g] = (|l2[g*fag_pkg::NS +: fag_pkg::NS]) & ~mask_q[g];
    assign clr_vec[g*fag_pkg::NB +: fag_pkg::NB] = {fag_pkg::NB{clr_grp[g]}};
  end

  // Latch; a live cause beats the clear, so persisting faults survive it
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      l3_q <= '0;
    else
      l3_q <= cond_vec | (l3_q & ~clr_vec);
  end

  // Fault pin: open drain, data fixed low, enable active low
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      fault_out_o <= 1'b0;
      fault_out_oe_n <= 1'b1;
    end
    else
      fault_out_oe_n <= ~(conf_q[fag_pkg::CONF_FAULT_OUT] & (|summary));
  end

  // Tone receive gate: sleep or validate, receiver enabled
  assign tone_ok = tone_rx.burst && conf_q[fag_pkg::CONF_TONE_RX]
                   && (mode_q == fag_pkg::MODE_SLEEP || mode_q == fag_pkg::MODE_VALIDATE);
  assign tone_confirm = tone_ok && tone_rx.is_fault && burst_q == 2'(fag_pkg::FT_BURSTS - 1);
  assign ftone_set = (mode_q == fag_pkg::MODE_ACTIVE && frame_fault_embed) || tone_confirm;

  // Fault tone needs repeated bursts; a single burst is a comm tone
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      burst_q <= 2'h0;
      gap_q <= '0;
    end
    else if (tone_ok && tone_rx.is_fault)
    begin
      burst_q <= tone_confirm ? 2'h0 : burst_q + 2'h1;
      gap_q <= '0;
    end
    else if (gap_q == GPW'(FT_GAP_CYC))
      burst_q <= 2'h0;
    else if (burst_q != 2'h0)
      gap_q <= gap_q + 1'b1;
  end

  // Heartbeat transmit; this end never sends fault tones
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      hb_cnt_q <= '0;
      hb_tx_pulse <= 1'b0;
      tone_tx_high_side <= 1'b0;
      tone_rx_active <= 1'b0;
    end
    else
    begin
      hb_tx_pulse <= 1'b0;
      tone_tx_high_side <= ~conf_q[fag_pkg::CONF_DIR_SEL];
      tone_rx_active <= conf_q[fag_pkg::CONF_TONE_RX]
                        && (mode_q == fag_pkg::MODE_SLEEP || mode_q == fag_pkg::MODE_VALIDATE);
      if (mode_q != fag_pkg::MODE_SLEEP || !conf_q[fag_pkg::CONF_HB_TX])
        hb_cnt_q <= '0;
      else if (hb_cnt_q == HBW'(HB_PERIOD_CYC - 1))
      begin
        hb_cnt_q <= '0;
        hb_tx_pulse <= 1'b1;
      end
      else
        hb_cnt_q <= hb_cnt_q + 1'b1;
    end
  end

  // Sniffer arming sampled on entry to shutdown; reset leaves it off
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      armed_q <= 1'b0;
    else if (mode_d == fag_pkg::MODE_SHUTDOWN && mode_q != fag_pkg::MODE_SHUTDOWN)
      armed_q <= conf_q[fag_pkg::CONF_SNIFF_EN] & ~conf_q[fag_pkg::CONF_SNIFF_DIS];
  end

  // Couplet counter; positive couplets are not expected and restart it
  assign sniff_hit = armed_q && mode_q == fag_pkg::MODE_SHUTDOWN && sniff_couplet_neg
                     && sniff_cnt_q == SCW'(SNIFF_THR - 1);
  always_ff @(posedge ref_clk)
  begin
    if (rst || !armed_q || mode_q != fag_pkg::MODE_SHUTDOWN)
    begin
      sniff_cnt_q <= '0;
      idle_q <= '0;
    end
    else if (sniff_couplet_neg)
    begin
      sniff_cnt_q <= sniff_hit ? '0 : sniff_cnt_q + 1'b1;
      idle_q <= '0;
    end
    else if (sniff_couplet_pos || idle_q == SIW'(fag_pkg::SNIFF_IDLE_CYC))
    begin
      sniff_cnt_q <= '0;
      idle_q <= '0;
    end
    else if (sniff_cnt_q != '0)
      idle_q <= idle_q + 1'b1;
  end

  // Mode sequencing; validate window falls back to shutdown
  always_comb
  begin
    mode_d = mode_q;
    case (mode_q)
      fag_pkg::MODE_ACTIVE:
        if (goto_shutdown)
          mode_d = fag_pkg::MODE_SHUTDOWN;
        else if (goto_sleep)
          mode_d = fag_pkg::MODE_SLEEP;
      fag_pkg::MODE_SLEEP:
        if (goto_active)
          mode_d = fag_pkg::MODE_ACTIVE;
        else if (goto_shutdown)
          mode_d = fag_pkg::MODE_SHUTDOWN;
      fag_pkg::MODE_SHUTDOWN:
        if (goto_active)
          mode_d = fag_pkg::MODE_ACTIVE;
        else if (sniff_hit)
          mode_d = fag_pkg::MODE_VALIDATE;
      default:
        if (goto_active)
          mode_d = fag_pkg::MODE_ACTIVE;
        else if (val_q == VLW'(VALIDATE_CYC - 1))
          mode_d = fag_pkg::MODE_SHUTDOWN;
    endcase
  end

  // Mode state and validate window counter
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      mode_q <= fag_pkg::MODE_SHUTDOWN;
      val_q <= '0;
    end
    else
    begin
      mode_q <= mode_d;
      val_q <= (mode_q == fag_pkg::MODE_VALIDATE && mode_d == fag_pkg::MODE_VALIDATE) ? val_q + 1'b1 : '0;
    end
  end
  assign mode = mode_q;

  // Wake triggers; uses latched flags so the mask plays no part
  assign wake_trig = !dis_all && (
                     ((mode_q == fag_pkg::MODE_SLEEP || mode_q == fag_pkg::MODE_VALIDATE)
                      && (|l3_q[fag_pkg::SYS_CONF:fag_pkg::SYS_FTONE]))
                     || (mode_q == fag_pkg::MODE_ACTIVE && force_wr));

  // Wake stays on in every mode until rst
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      wake_q <= 1'b0;
      host_wake_o <= 1'b0;
      host_wake_oe_n <= 1'b1;
    end
    else
    begin
      wake_q <= wake_q | wake_trig;
      host_wake_o <= 1'b1;
      host_wake_oe_n <= ~wake_q;
    end
  end

  a_latch_holds: assert property (@(posedge ref_clk) disable iff (rst)
    1'b1 |=> (($past(l3_q) & ~$past(clr_vec) & ~l3_q) == '0))
    else $error("latched fault bit lost without clear");
  a_persist_clear: assert property (@(posedge ref_clk) disable iff (rst)
    1'b1 |=> (($past(cond_vec) & ~l3_q) == '0))
    else $error("fault with live cause was cleared");
  a_summary_sets: assert property (@(posedge ref_clk) disable iff (rst)
    (l3_q[fag_pkg::NB] && !mask_q[1]) |-> summary[1])
    else $error("summary missed a group fault");
  a_mask_blocks: assert property (@(posedge ref_clk) disable iff (rst)
    mask_q[2] |-> !summary[2])
    else $error("masked group reached summary");
  a_pin_drives: assert property (@(posedge ref_clk) disable iff (rst)
    (conf_q[fag_pkg::CONF_FAULT_OUT] && (|summary)) |=> !fault_out_oe_n)
    else $error("fault pin not pulled on unmasked fault");
  a_pin_disabled: assert property (@(posedge ref_clk) disable iff (rst)
    !conf_q[fag_pkg::CONF_FAULT_OUT] |=> fault_out_oe_n)
    else $error("disabled fault pin driven");
  a_wake_latched: assert property (@(posedge ref_clk) disable iff (rst)
    !host_wake_oe_n |=> !host_wake_oe_n[*3])
    else $error("wake output released");
  a_wake_blocked: assert property (@(posedge ref_clk) disable iff (rst)
    (dis_all && !wake_q) |=> !wake_q)
    else $error("wake fired while disabled");
  a_active_force: assert property (@(posedge ref_clk) disable iff (rst)
    (mode_q == fag_pkg::MODE_ACTIVE && !force_wr && !wake_q) |=> !wake_q ##1 host_wake_oe_n)
    else $error("active wake without force write");
  a_sniff_validate: assert property (@(posedge ref_clk) disable iff (rst)
    (sniff_hit && !goto_active) |=> mode_q == fag_pkg::MODE_VALIDATE)
    else $error("sniffer hit did not enter validate");
  a_hb_sleep: assert property (@(posedge ref_clk) disable iff (rst)
    hb_tx_pulse |-> ($past(mode_q) == fag_pkg::MODE_SLEEP && $past(conf_q[fag_pkg::CONF_HB_TX])))
    else $error("heartbeat sent outside enabled sleep");
endmodule
`default_nettype wire

// >>> verif/fag_chain_model.sv
/*
  Far-side model: stacked monitors that send tones, sniffer couplets and
  embedded frame faults, plus the board pulls on the fault and wake pins.
  Assumes the bench calls its tasks from the ref_clk domain.
*/
`timescale 1ns/1ps
`default_nettype none
module fag_chain_model (
  input wire logic ref_clk,
  input wire logic fault_out_o,
  input wire logic fault_out_oe_n,
  input wire logic host_wake_o,
  input wire logic host_wake_oe_n,
  output var fag_pkg::fag_tone_t tone_rx,
  output var logic sniff_couplet_neg,
  output var logic sniff_couplet_pos,
  output var logic frame_fault_embed,
  output wire logic fault_pin_n,
  output wire logic wake_pin
);
  // Host pull-up on the fault line, board pull-down on the wake line
  assign fault_pin_n = fault_out_oe_n ? 1'h1 : fault_out_o;
  assign wake_pin = host_wake_oe_n ? 1'h0 : host_wake_o;

  // Quiet lines until a task speaks
  initial
  begin
    tone_rx = '0;
    sniff_couplet_neg = 1'h0;
    sniff_couplet_pos = 1'h0;
    frame_fault_embed = 1'h0;
  end

  // Tones repeat their burst periodically, unlike a one-shot comm tone
  task automatic tones(input logic is_fault, input int n, input int gap);
    repeat (n)
    begin
      @(posedge ref_clk);
      tone_rx <= '{burst: 1'h1, is_fault: is_fault};
      @(posedge ref_clk);
      tone_rx <= '0;
      repeat (gap - 2) @(posedge ref_clk);
    end
  endtask

  // Couplets four cycles apart, far inside the idle limit
  task automatic couplets(input int n, input logic pos);
    repeat (n)
    begin
      @(posedge ref_clk);
      sniff_couplet_neg <= !pos;
      sniff_couplet_pos <= pos;
      @(posedge ref_clk);
      sniff_couplet_neg <= 1'h0;
      sniff_couplet_pos <= 1'h0;
      repeat (2) @(posedge ref_clk);
    end
  endtask

  // One response frame carrying a stack fault
  task automatic embed();
    @(posedge ref_clk);
    frame_fault_embed <= 1'h1;
    @(posedge ref_clk);
    frame_fault_embed <= 1'h0;
  endtask
endmodule
`default_nettype wire

// >>> verif/tb_top.sv
/*
  Self-checking bench for fag_top: APB master, a table of fault patterns,
  then hand-written wake, tone and sniffer cases.
  Assumes fag_chain_model stands at the far side of the chain.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  typedef struct packed {logic [23:0] fc; logic [3:0] mask; logic [3:0] sum; logic pin_n;} fag_tb_row_t;
  localparam fag_tb_row_t ROWS [5] = '{'{24'h000001, 4'h0, 4'h2, 1'h0}, '{24'h000100, 4'h4, 4'h0, 1'h1},
    '{24'h800000, 4'h0, 4'h8, 1'h0}, '{24'h010110, 4'h2, 4'hC, 1'h0}, '{24'hFFFFFF, 4'hE, 4'h0, 1'h1}};
  logic ref_clk = 1'h0;
  logic rst = 1'h1;
  logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdata;
  logic pready, pslverr, fault_out_o, fault_out_oe_n, host_wake_o, host_wake_oe_n, last_err;
  logic hb_tx_pulse, tone_tx_high_side, tone_rx_active, frame_fault_embed;
  logic sniff_couplet_neg, sniff_couplet_pos, fault_pin_n, wake_pin;
  logic [2:0] gotos = 3'h0;
  logic [23:0] fault_cond = 24'h0;
  fag_pkg::fag_sys_cond_t sys_cond = '0;
  fag_pkg::fag_tone_t tone_rx;
  fag_pkg::fag_mode_t mode;
  int failures = 0;
  int samples_checked = 0;
  int hb_cnt;

  // 100 MHz clock
  always #5 ref_clk = ~ref_clk;

  // Short counts keep the run brief; sniffer threshold left as built
  fag_top #(.HB_PERIOD_CYC(50), .FT_GAP_CYC(100), .VALIDATE_CYC(200), .SNIFF_THR(32)) u_dut (
    .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .goto_active(gotos[0]),
    .goto_sleep(gotos[1]), .goto_shutdown(gotos[2]), .frame_fault_embed(frame_fault_embed),
    .tone_rx(tone_rx), .sniff_couplet_neg(sniff_couplet_neg), .sniff_couplet_pos(sniff_couplet_pos),
    .sys_cond(sys_cond), .fault_cond(fault_cond), .host_wake_pin_level(wake_pin),
    .fault_out_o(fault_out_o), .fault_out_oe_n(fault_out_oe_n), .host_wake_o(host_wake_o),
    .host_wake_oe_n(host_wake_oe_n), .hb_tx_pulse(hb_tx_pulse), .tone_tx_high_side(tone_tx_high_side),
    .tone_rx_active(tone_rx_active), .mode(mode));

  fag_chain_model u_chain (
    .ref_clk(ref_clk), .fault_out_o(fault_out_o), .fault_out_oe_n(fault_out_oe_n),
    .host_wake_o(host_wake_o), .host_wake_oe_n(host_wake_oe_n), .tone_rx(tone_rx),
    .sniff_couplet_neg(sniff_couplet_neg), .sniff_couplet_pos(sniff_couplet_pos),
    .frame_fault_embed(frame_fault_embed), .fault_pin_n(fault_pin_n), .wake_pin(wake_pin));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'h1;
    // No local limit; a hung slave is caught by the watchdog
    do
    begin
      @(posedge ref_clk);
    end
    while (pready !== 1'h1);
    rdata = prdata;
    last_err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'h0, a, 32'h0);
    chk(rdata, exp);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic go(input logic [2:0] g);
    @(posedge ref_clk);
    gotos <= g;
    @(posedge ref_clk);
    gotos <= 3'h0;
  endtask

  task automatic do_reset();
    @(posedge ref_clk);
    rst <= 1'h1;
    sys_cond <= '0;
    fault_cond <= 24'h0;
    repeat (10) @(posedge ref_clk);
    rst <= 1'h0;
    @(posedge ref_clk);
  endtask

  task automatic count_hb();
    hb_cnt = 0;
    repeat (120)
    begin
      @(posedge ref_clk);
      if (hb_tx_pulse === 1'h1)
        hb_cnt++;
    end
  endtask

  function automatic logic [7:0] l2_of(input logic [31:0] l3);
    for (int i = 0; i < 8; i++)
      l2_of[i] = |l3[i*4 +: 4];
  endfunction

  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Main sequence: table first, awkward cases after
  initial
  begin
    do_reset();
    chk({30'h0, fault_pin_n, wake_pin}, 32'h2);
    rd(fag_pkg::ADDR_CONF, 32'h2);
    rd(fag_pkg::ADDR_STATUS, 32'h2);
    apb(1'h0, 8'h20, 32'h0);
    chk({31'h0, last_err}, 32'h1);
    $display("test reset done");
    go(3'h1);
    foreach (ROWS[i])
    begin
      wr(fag_pkg::ADDR_MASK, {28'h0, ROWS[i].mask});
      fault_cond <= ROWS[i].fc;
      cyc(2);
      fault_cond <= 24'h0;
      cyc(3);
      rd(fag_pkg::ADDR_LEVEL3, {ROWS[i].fc, 8'h00});
      rd(fag_pkg::ADDR_LEVEL2, {24'h0, l2_of({ROWS[i].fc, 8'h00})});
      rd(fag_pkg::ADDR_SUMMARY, {28'h0, ROWS[i].sum});
      chk({31'h0, fault_pin_n}, {31'h0, ROWS[i].pin_n});
      wr(fag_pkg::ADDR_CLEAR, 32'hE);
      rd(fag_pkg::ADDR_LEVEL3, 32'h0);
    end
    $display("test table done");
    // A persisting cause survives the clear; pin off keeps summary
    wr(fag_pkg::ADDR_MASK, 32'h0);
    fault_cond <= 24'h1;
    wr(fag_pkg::ADDR_CLEAR, 32'h2);
    rd(fag_pkg::ADDR_LEVEL3, 32'h100);
    wr(fag_pkg::ADDR_CONF, 32'h0);
    cyc(2);
    rd(fag_pkg::ADDR_SUMMARY, 32'h2);
    chk({31'h0, fault_pin_n}, 32'h1);
    fault_cond <= 24'h0;
    wr(fag_pkg::ADDR_CLEAR, 32'h2);
    u_chain.embed();
    cyc(2);
    rd(fag_pkg::ADDR_LEVEL3, 32'h1);
    wr(fag_pkg::ADDR_CLEAR, 32'h1);
    $display("test clear done");
    // Active mode wakes on the force bit only, then stays latched
    sys_cond <= '1;
    cyc(6);
    chk({31'h0, wake_pin}, 32'h0);
    sys_cond <= '0;
    wr(fag_pkg::ADDR_CLEAR, 32'h1);
    wr(fag_pkg::ADDR_WAKE, 32'h4);
    cyc(3);
    chk({31'h0, wake_pin}, 32'h1);
    rd(fag_pkg::ADDR_LEVEL3, 32'h40);
    go(3'h2);
    cyc(4);
    chk({31'h0, wake_pin}, 32'h1);
    wr(fag_pkg::ADDR_WAKE, 32'h3);
    wr(fag_pkg::ADDR_CLEAR, 32'h1);
    rd(fag_pkg::ADDR_LEVEL3, 32'h0);
    wr(fag_pkg::ADDR_WAKE, 32'h0);
    rd(fag_pkg::ADDR_WAKE, 32'h300);
    $display("test force done");
    // Sleep: receiver gating, heartbeat gating, direction, masked wake
    do_reset();
    go(3'h1);
    go(3'h2);
    wr(fag_pkg::ADDR_MASK, 32'hF);
    u_chain.tones(1'h1, 3, 50);
    cyc(3);
    rd(fag_pkg::ADDR_LEVEL3, 32'h0);
    chk({31'h0, wake_pin}, 32'h0);
    chk({31'h0, tone_rx_active}, 32'h0);
    wr(fag_pkg::ADDR_CONF, 32'h06);
    cyc(2);
    chk({31'h0, tone_tx_high_side}, 32'h1);
    chk({31'h0, tone_rx_active}, 32'h1);
    count_hb();
    chk(hb_cnt, 0);
    u_chain.tones(1'h0, 3, 50);
    // Two fault bursts then a long gap must not count as a fault tone
    u_chain.tones(1'h1, 2, 50);
    cyc(60);
    rd(fag_pkg::ADDR_LEVEL3, 32'h0);
    u_chain.tones(1'h1, 3, 50);
    cyc(3);
    rd(fag_pkg::ADDR_LEVEL3, 32'h41);
    chk({31'h0, wake_pin}, 32'h1);
    wr(fag_pkg::ADDR_CONF, 32'h27);
    cyc(2);
    chk({31'h0, tone_tx_high_side}, 32'h0);
    count_hb();
    chk({31'h0, hb_cnt >= 2}, 32'h1);
    $display("test sleep done");
    // Each sleep condition wakes the host unless the field disarms it
    for (int i = 0; i < 5; i++)
    begin
      do_reset();
      go(3'h1);
      go(3'h2);
      wr(fag_pkg::ADDR_WAKE, 32'h3);
      sys_cond <= fag_pkg::fag_sys_cond_t'(5'h10 >> i);
      cyc(6);
      chk({31'h0, wake_pin}, 32'h0);
      wr(fag_pkg::ADDR_WAKE, 32'h0);
      cyc(6);
      chk({31'h0, wake_pin}, 32'h1);
    end
    $display("test wake sources done");
    // Sniffer: idle gap restarts the count, full run enters validate
    do_reset();
    wr(fag_pkg::ADDR_CONF, 32'h16);
    go(3'h1);
    go(3'h4);
    rd(fag_pkg::ADDR_STATUS, 32'h6);
    u_chain.couplets(31, 1'h0);
    cyc(210);
    u_chain.couplets(31, 1'h0);
    cyc(2);
    rd(fag_pkg::ADDR_STATUS, 32'h6);
    // A positive couplet restarts the count, so one more negative is no hit
    u_chain.couplets(1, 1'h1);
    u_chain.couplets(1, 1'h0);
    rd(fag_pkg::ADDR_STATUS, 32'h6);
    cyc(210);
    u_chain.couplets(32, 1'h0);
    chk({30'h0, mode}, {30'h0, fag_pkg::MODE_VALIDATE});
    u_chain.tones(1'h1, 3, 50);
    cyc(3);
    rd(fag_pkg::ADDR_LEVEL3, 32'hC1);
    chk({31'h0, wake_pin}, 32'h1);
    // Disable bit overrides enable
    do_reset();
    wr(fag_pkg::ADDR_CONF, 32'h1A);
    go(3'h1);
    go(3'h4);
    rd(fag_pkg::ADDR_STATUS, 32'h2);
    u_chain.couplets(32, 1'h0);
    chk({30'h0, mode}, {30'h0, fag_pkg::MODE_SHUTDOWN});
    $display("test sniffer done");
    final_report();
  end

  // Watchdog: the sequence needs about 2500 cycles
  initial
  begin
    repeat (30000) @(posedge ref_clk);
    failures++;
    final_report();
  end
endmodule
`default_nettype wire
